// >>> testbench/ueb_core_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module ueb_core_tb_top;
	import ueb_pkg::*;
	localparam int RES_CYC = 20; // Shortened resume length
	localparam int PKT     = 4;  // Shortened main packet
	logic        clk, srst, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        out_done, in_sent, setup_rx, sof_rx, dma_wr, end_of_transfer_n, norm_irq;
	logic [2:0]  usb_ep, dma_slot;
	logic [10:0] sof_frame;
	logic [7:0]  dma_data, dma_len;
	logic [6:0]  buf_full, tx_enable;
	logic [5:0]  ep_stall, ep_reinit;
	logic        dma_send, resume_out, int_n;
	int          errors = 0, n_tests = 0, n_send = 0, int_lows = 0, n, b, i;
	logic [5:0]  reinit_seen = 6'h00; // Sticky record of reinit pulses
	logic [7:0]  last_len;
	logic [2:0]  last_slot;
	ueb_core #(.RESUME_CYCLES(RES_CYC), .DMA_PKT(PKT)) uut (
		.REF_CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .OUT_DONE(out_done), .IN_SENT(in_sent), .USB_EP(usb_ep),
		.SETUP_RX(setup_rx), .SOF_RX(sof_rx), .SOF_FRAME(sof_frame), .NORM_IRQ(norm_irq),
		.DMA_WR(dma_wr), .DMA_DATA(dma_data), .END_OF_TRANSFER_N(end_of_transfer_n),
		.BUF_FULL(buf_full), .TX_ENABLE(tx_enable), .EP_STALL(ep_stall),
		.EP_REINIT(ep_reinit), .DMA_SEND(dma_send), .DMA_LEN(dma_len),
		.DMA_SLOT(dma_slot), .RESUME_OUT(resume_out), .INT_N(int_n));
	ueb_usb_model u_far (.clk(clk), .out_done(out_done), .in_sent(in_sent),
		.usb_ep(usb_ep), .setup_rx(setup_rx), .sof_rx(sof_rx), .sof_frame(sof_frame),
		.dma_wr(dma_wr), .dma_data(dma_data), .end_of_transfer_n(end_of_transfer_n));
	// Free-running 50 MHz clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Watchers for one-cycle outputs; reset time is skipped to avoid unknowns
	always @(posedge clk) begin
		if (srst === 1'b0) begin
			reinit_seen <= reinit_seen | ep_reinit;
			if (int_n === 1'b0) int_lows <= int_lows + 1;
			if (dma_send === 1'b1) begin
				n_send <= n_send + 1;
				last_len <= dma_len;
				last_slot <= dma_slot;
			end
		end
	end
	// Verdict and end of run
	task automatic close_out();
		$display("Comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : close_out
	// Value comparison
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// One APB transfer; waits for pready under a bound
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (k = 0; k < 16; k++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		if (k == 16) begin
			errors++;
			close_out();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic cmd(input logic [7:0] c);
		apb(1'b1, REG_CMD, {24'h0, c});
	endtask : cmd
	task automatic idle(input int c);
		repeat (c) @(posedge clk);
	endtask : idle
	// Main sequence
	initial begin : main
		logic [31:0] modes [4] = '{32'h0, 32'h2000, 32'h80, 32'h2080};
		srst = 1'b1;
		{psel, penable, pwrite, norm_irq} = 4'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		apb(1'b0, REG_STAT, 32'h0);
		chk("stat reset", 32'h0, rd);
		chk("int idle", 32'h1, {31'h0, int_n});
		apb(1'b0, 12'h020, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, err});
		// Fill and validate IN endpoint 3
		cmd(8'h03);
		cmd(CMD_BUF);
		wr(REG_DATA, 32'h0);
		wr(REG_DATA, 32'h2);
		wr(REG_DATA, 32'hA5);
		wr(REG_DATA, 32'h5A);
		idle(2);
		chk("in before validate", 32'h0, {31'h0, buf_full[3]});
		cmd(CMD_VALID);
		idle(2);
		chk("in tx", 32'h1, {31'h0, tx_enable[3]});
		apb(1'b0, REG_STAT, 32'h0);
		chk("stat full", 32'h80, rd & 32'h7F0);
		u_far.ev(1, 3'h3);
		idle(2);
		chk("in sent", 32'h0, {31'h0, buf_full[3]});
		// OUT packet, unknown code, clear
		u_far.ev(0, 3'h2);
		idle(2);
		chk("out full", 32'h1, {31'h0, buf_full[2]});
		cmd(8'h02);
		cmd(CMD_BUF);
		apb(1'b0, REG_DATA, 32'h0);
		cmd(8'hF3);
		idle(2);
		chk("unknown code", 32'h1, {31'h0, buf_full[2]});
		cmd(CMD_CLRBUF);
		idle(2);
		chk("out clear", 32'h0, {31'h0, buf_full[2]});
		// Stall, flush on unstall, zero write
		cmd(8'h42);
		wr(REG_DATA, 32'h1);
		u_far.ev(0, 3'h2);
		idle(2);
		chk("stall", 32'h1, {31'h0, ep_stall[2]});
		chk("no reinit", 32'h0, {31'h0, reinit_seen[2]});
		cmd(8'h42);
		wr(REG_DATA, 32'h0);
		idle(2);
		chk("unstall", {31'h0, 1'b1}, {31'h0, ~ep_stall[2] & reinit_seen[2]});
		chk("flush", 32'h0, {31'h0, buf_full[2]});
		cmd(8'h43);
		wr(REG_DATA, 32'h0);
		idle(2);
		chk("zero reinit", 32'h1, {31'h0, reinit_seen[3]});
		// SETUP handling
		cmd(8'h01);
		cmd(CMD_VALID);
		cmd(8'h40);
		wr(REG_DATA, 32'h1);
		u_far.ev(2, 3'h0);
		idle(2);
		chk("setup unstall", 32'h0, {31'h0, ep_stall[0]});
		chk("setup kept", 32'h1, {31'h0, buf_full[0]});
		chk("in flushed", 32'h0, {31'h0, buf_full[1]});
		apb(1'b0, REG_STAT, 32'h0);
		chk("blocked", 32'h60000, rd & 32'h60000);
		cmd(8'h00);
		cmd(CMD_CLRBUF);
		cmd(8'h01);
		cmd(CMD_VALID);
		idle(2);
		chk("blocked cmds", 32'h1, {30'h0, buf_full[1:0]});
		cmd(8'h00);
		cmd(CMD_ACKSET);
		cmd(8'h01);
		cmd(CMD_ACKSET);
		cmd(CMD_VALID);
		cmd(8'h00);
		cmd(CMD_CLRBUF);
		idle(2);
		chk("unblocked", 32'h2, {30'h0, tx_enable[1], buf_full[0]});
		// Resume length
		cmd(CMD_RESUME);
		n = 0;
		for (i = 0; i < 200; i++) begin
			@(posedge clk);
			if (resume_out === 1'b1) n++;
		end
		chk("resume", RES_CYC, n);
		// Frame number, low byte first
		u_far.sof(11'h5A3);
		cmd(CMD_FRAME);
		apb(1'b0, REG_DATA, 32'h0);
		chk("frame lo", 32'hA3, rd);
		apb(1'b0, REG_DATA, 32'h0);
		chk("frame hi", 32'h05, rd);
		// Interrupt source modes
		for (i = 0; i < 4; i++) begin
			wr(REG_CFG, modes[i]);
			norm_irq <= 1'b1;
			idle(3);
			chk("int norm", {31'h0, modes[i][7]}, {31'h0, int_n});
			norm_irq <= 1'b0;
			idle(3);
			b = int_lows;
			u_far.sof(11'h001);
			idle(3);
			chk("int sof", {31'h0, i != 0}, {31'h0, int_lows != b});
		end
		// DMA double buffering
		for (i = 0; i < PKT - 1; i++) u_far.dma(i[7:0], 1'b0);
		idle(3);
		chk("no partial", 32'h0, n_send);
		u_far.dma(8'h03, 1'b0);
		idle(3);
		chk("full send", {21'h1, 8'(PKT), 3'h5}, {n_send[20:0], last_len, last_slot});
		chk("dma full", 32'h1, {31'h0, buf_full[5]});
		u_far.dma(8'h10, 1'b0);
		u_far.dma(8'h11, 1'b1);
		idle(3);
		chk("eot send", {21'h2, 8'h02, 3'h6}, {n_send[20:0], last_len, last_slot});
		close_out();
	end
endmodule : ueb_core_tb_top
`default_nettype wire

// >>> testbench/ueb_usb_model.sv
`timescale 1ns/1ps
`default_nettype none
// Far side stand-in: USB engine events and the DMA controller
module ueb_usb_model (
	input  wire logic        clk,
	output logic             out_done,
	output logic             in_sent,
	output logic      [2:0]  usb_ep,
	output logic             setup_rx,
	output logic             sof_rx,
	output logic      [10:0] sof_frame,
	output logic             dma_wr,
	output logic      [7:0]  dma_data,
	output logic             end_of_transfer_n
);
	// Quiet bus at time zero
	initial begin
		{out_done, in_sent, setup_rx, sof_rx, dma_wr} = 5'h0;
		usb_ep = 3'h7;
		sof_frame = 11'h000;
		dma_data = 8'h00;
		end_of_transfer_n = 1'b1;
	end
	// One-cycle packet event; kind 0 OUT done, 1 IN sent, 2 SETUP
	task automatic ev(input int kind, input logic [2:0] ep);
		@(posedge clk);
		usb_ep <= ep;
		out_done <= (kind == 0);
		in_sent <= (kind == 1);
		setup_rx <= (kind == 2);
		@(posedge clk);
		{out_done, in_sent, setup_rx} <= 3'h0;
		usb_ep <= ~ep; // Stale index is scrambled so it cannot be trusted
	endtask : ev
	// Good frame start with its number
	task automatic sof(input logic [10:0] fr);
		@(posedge clk);
		sof_rx <= 1'b1;
		sof_frame <= fr;
		@(posedge clk);
		sof_rx <= 1'b0;
		sof_frame <= ~fr;
	endtask : sof
	// One DMA byte, optionally closing the transfer
	task automatic dma(input logic [7:0] d, input logic last);
		@(posedge clk);
		dma_wr <= 1'b1;
		dma_data <= d;
		end_of_transfer_n <= ~last;
		@(posedge clk);
		dma_wr <= 1'b0;
		dma_data <= ~d;
		end_of_transfer_n <= 1'b1;
	endtask : dma
endmodule : ueb_usb_model
`default_nettype wire

// >>> verilog/ueb_core.sv
// Behaviour
// - Buffer write command loads at most 130 bytes
// - DMA writes skip the two header bytes
// - Bulk buffer sent once completely filled
// - End of transfer sends partial buffer
// - Main endpoint DMA switches to second buffer
// - Received OUT packet sets full, then NAK
// - Clear command releases OUT buffer
// - Validate command marks IN buffer full
// - Status command stalls; SETUP unstalls control endpoint
// - Unstall flushes buffer and resets data toggle
// - Writing zero status always reinitializes endpoint
// - SETUP flushes IN, blocks validate and clear
// - Pending SETUP kept, control IN endpoint not sent upstream
// - Resume command drives resume for 10 ms
// - Frame command returns frame number, low first
// - Interrupt source chosen by two mode bits
// - Mode bits: clock byte bit7, DMA bit5
// - Buffer: reserved, length, then payload
// - Each buffer read, and each write up to the limit, advances pointer by one
// - Select command resets buffer pointer
`timescale 1ns/1ps
`default_nettype none
module ueb_core #(
	parameter int RESUME_CYCLES = ueb_pkg::RESUME_CYC, // Shorten for simulation
	parameter int DMA_PKT       = 64                   // Main endpoint packet size
) (
	input  wire logic        REF_CLK,
	input  wire logic        SRST,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic        OUT_DONE,
	input  wire logic        IN_SENT,
	input  wire logic [2:0]  USB_EP,
	input  wire logic        SETUP_RX,
	input  wire logic        SOF_RX,
	input  wire logic [10:0] SOF_FRAME,
	input  wire logic        NORM_IRQ,
	input  wire logic        DMA_WR,
	input  wire logic [7:0]  DMA_DATA,
	input  wire logic        END_OF_TRANSFER_N,
	output logic      [6:0]  BUF_FULL,
	output logic      [6:0]  TX_ENABLE,
	output logic      [5:0]  EP_STALL,
	output logic      [5:0]  EP_REINIT,
	output logic             DMA_SEND,
	output logic      [7:0]  DMA_LEN,
	output logic      [2:0]  DMA_SLOT,
	output logic             RESUME_OUT,
	output logic             INT_N
);
	import ueb_pkg::*;

	// Buffer address from slot and byte pointer
	function automatic logic [10:0] baddr(input logic [2:0] slot, input logic [7:0] p);
		baddr = {slot, p};
	endfunction : baddr

	logic [7:0]  mem [0:2047];       // All endpoint buffers, 256 bytes per slot
	logic [7:0]  cmd_q, cmd_d;       // Last command code
	logic [2:0]  sel_q, sel_d;       // Selected endpoint
	logic [7:0]  ptr_q, ptr_d;       // Buffer pointer of selected endpoint
	logic [7:0]  cnt_q, cnt_d;       // Data phase byte count
	logic [6:0]  full_q, full_d;     // Buffer full flags per slot
	logic [5:0]  stall_q, stall_d;   // Stall state per endpoint
	logic [1:0]  blk_q, blk_d;       // Setup block, control OUT and IN
	logic [10:0] frame_q, frame_d;   // Frame of last good SOF
	logic        fsel_q, fsel_d;     // Next frame byte is the high one
	logic [15:0] cfg_q, cfg_d;       // Clock division byte and DMA byte
	logic [18:0] res_q, res_d;       // Resume time left
	logic [7:0]  dptr_q, dptr_d;     // DMA pointer
	logic        dalt_q, dalt_d;     // DMA fills the second buffer
	logic [5:0]  rein_q, rein_d;     // Reinit pulses
	logic        dsend_q, dsend_d;   // DMA buffer handed to the link
	logic [7:0]  dlen_q, dlen_d;     // Length of handed buffer
	logic [2:0]  dslot_q, dslot_d;   // Slot of handed buffer
	logic        int_q, int_d;       // Interrupt request
	logic [31:0] rd_q, rd_d;         // Read data
	logic        acc, wr_acc, rd_acc, mapped, cmd_wr, dat_wr, dat_rd;
	logic        buf_wr, dma_last, dma_flush;
	logic [2:0]  sts_ep, dslot;
	logic [7:0]  dlen;

	// Bus decode; zero wait states so the slave never stalls
	always_comb begin
		acc    = PSEL & PENABLE;
		wr_acc = acc & PWRITE;
		rd_acc = acc & ~PWRITE;
		mapped = (PADDR == REG_CMD) | (PADDR == REG_DATA) | (PADDR == REG_STAT)
			| (PADDR == REG_CFG) | (PADDR == REG_FRAME);
		cmd_wr = wr_acc & (PADDR == REG_CMD);
		dat_wr = wr_acc & (PADDR == REG_DATA);
		dat_rd = rd_acc & (PADDR == REG_DATA);
		sts_ep = cmd_q[2:0];
		// Host writes include the header bytes; host data must start at slot byte 0
		buf_wr = dat_wr & (cmd_q == CMD_BUF) & (cnt_q < MAX_XFER);
		dslot  = dalt_q ? EP_ALT_BUF : EP_MAIN_IN;
		dma_last  = DMA_WR & (dptr_q == 8'(HDR_BYTES + DMA_PKT - 1));
		dma_flush = ~END_OF_TRANSFER_N & (DMA_WR | (dptr_q != HDR_BYTES));
		dlen = 8'(dptr_q - HDR_BYTES + {7'h00, DMA_WR});
	end

	// Buffer memory: bus and DMA ports; range and direction left to the host
	always_ff @(posedge REF_CLK) begin
		if (buf_wr) begin
			mem[baddr(sel_q, ptr_q)] <= PWDATA[7:0];
		end
		if (DMA_WR) begin
			mem[baddr(dslot, dptr_q)] <= DMA_DATA;
		end
	end

	// Next state of commands, flags, DMA and timers
	always_comb begin
		cmd_d = cmd_q; sel_d = sel_q; ptr_d = ptr_q; cnt_d = cnt_q;
		full_d = full_q; stall_d = stall_q; blk_d = blk_q; frame_d = frame_q;
		fsel_d = fsel_q; cfg_d = cfg_q; dptr_d = dptr_q; dalt_d = dalt_q;
		rein_d = 6'h00; dsend_d = 1'b0; dlen_d = dlen_q; dslot_d = dslot_q;
		res_d = (res_q != 19'h00000) ? 19'(res_q - 19'h00001) : res_q;
		rd_d = rd_q;
		// Link takes IN data; cleared first so software sets win
		if (IN_SENT) begin
			full_d[USB_EP] = 1'b0;
		end
		// Command write; any new code ends the old data phase
		if (cmd_wr) begin
			cmd_d  = PWDATA[7:0];
			cnt_d  = 8'h00;
			fsel_d = 1'b0;
			if (PWDATA[7:0] <= CMD_SEL_HI) begin
				sel_d = PWDATA[2:0];
				ptr_d = 8'h00;
			end else if (PWDATA[7:0] == CMD_CLRBUF) begin
				if (!(sel_q < 3'h2 && blk_q[sel_q[0]])) begin
					full_d[sel_q] = 1'b0;
				end
			end else if (PWDATA[7:0] == CMD_VALID) begin
				if (!(sel_q < 3'h2 && blk_q[sel_q[0]])) begin
					full_d[sel_q] = 1'b1;
				end
			end else if (PWDATA[7:0] == CMD_ACKSET) begin
				if (sel_q < 3'h2) begin
					blk_d[sel_q[0]] = 1'b0;
				end
			end else if (PWDATA[7:0] == CMD_RESUME) begin
				res_d = 19'(RESUME_CYCLES);
			end
			// Other codes only set the data phase, which only buffer, status and frame codes act on
		end
		// Data write of the current command
		if (buf_wr) begin
			ptr_d = 8'(ptr_q + 8'h01);
			cnt_d = 8'(cnt_q + 8'h01);
		end
		if (dat_wr && cmd_q >= CMD_STS_LO && cmd_q <= CMD_STS_HI && cnt_q == 8'h00) begin
			cnt_d = 8'h01;
			stall_d[sts_ep] = PWDATA[0];
			if ((stall_q[sts_ep] && !PWDATA[0]) || PWDATA[7:0] == 8'h00) begin
				full_d[sts_ep] = 1'b0;
				rein_d[sts_ep] = 1'b1;
			end
		end
		// Data read side effects
		if (dat_rd && cmd_q == CMD_BUF) begin
			ptr_d = 8'(ptr_q + 8'h01);
		end
		if (dat_rd && cmd_q == CMD_FRAME) begin
			fsel_d = 1'b1;
		end
		if (wr_acc && PADDR == REG_CFG) begin
			cfg_d = PWDATA[15:0];
		end
		// Packet received on an OUT endpoint: full, NAK until cleared
		if (OUT_DONE) begin
			full_d[USB_EP] = 1'b1;
		end
		// SETUP: unstall control, flush IN, keep packet, block commands
		if (SETUP_RX) begin
			stall_d[1:0] = 2'b00;
			rein_d[1:0]  = rein_d[1:0] | stall_q[1:0];
			full_d[1]    = 1'b0;
			full_d[0]    = 1'b1;
			blk_d        = 2'b11;
		end
		if (SOF_RX) begin
			frame_d = SOF_FRAME;
		end
		// DMA into the main IN endpoint, two buffers in turn
		if (DMA_WR) begin
			dptr_d = 8'(dptr_q + 8'h01);
		end
		if (dma_last || (dma_flush && dlen != 8'h00)) begin
			full_d[dslot] = 1'b1;
			dsend_d = 1'b1;
			dlen_d  = dlen;
			dslot_d = dslot;
			dptr_d  = HDR_BYTES;
			dalt_d  = ~dalt_q;
		end
		// Interrupt source selection
		if (cfg_q[SOF_ONLY_BIT]) begin
			int_d = SOF_RX;
		end else begin
			int_d = NORM_IRQ | (cfg_q[INT_MODE_BIT] & SOF_RX);
		end
		// Read data latched in the setup cycle
		if (PSEL && !PENABLE && !PWRITE) begin
			case (PADDR)
				REG_DATA: begin
					if (cmd_q == CMD_BUF) begin
						rd_d = {24'h000000, mem[baddr(sel_q, ptr_q)]};
					end else if (cmd_q == CMD_FRAME) begin
						rd_d = fsel_q ? {29'h00000000, frame_q[10:8]}
							: {24'h000000, frame_q[7:0]};
					end else begin
						rd_d = 32'h00000000;
					end
				end
				REG_STAT:  rd_d = {13'h0000, blk_q, stall_q, full_q, 3'h0, res_q != 19'h00000};
				REG_CFG:   rd_d = {16'h0000, cfg_q};
				REG_FRAME: rd_d = {21'h000000, frame_q};
				default:   rd_d = 32'h00000000;
			endcase
		end
	end

	// State registers
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			cmd_q <= 8'hFF; sel_q <= 3'h0; ptr_q <= 8'h00; cnt_q <= 8'h00;
			full_q <= 7'h00; stall_q <= 6'h00; blk_q <= 2'h0; frame_q <= 11'h000;
			fsel_q <= 1'b0; cfg_q <= 16'h0000; res_q <= 19'h00000;
			dptr_q <= HDR_BYTES; dalt_q <= 1'b0; rein_q <= 6'h00; dsend_q <= 1'b0;
			dlen_q <= 8'h00; dslot_q <= 3'h0; int_q <= 1'b0; rd_q <= 32'h00000000;
		end else begin
			cmd_q <= cmd_d; sel_q <= sel_d; ptr_q <= ptr_d; cnt_q <= cnt_d;
			full_q <= full_d; stall_q <= stall_d; blk_q <= blk_d; frame_q <= frame_d;
			fsel_q <= fsel_d; cfg_q <= cfg_d; res_q <= res_d;
			dptr_q <= dptr_d; dalt_q <= dalt_d; rein_q <= rein_d; dsend_q <= dsend_d;
			dlen_q <= dlen_d; dslot_q <= dslot_d; int_q <= int_d; rd_q <= rd_d;
		end
	end

	// Outputs; control IN data held back while a SETUP is unacknowledged
	always_comb begin
		PRDATA     = rd_q;
		PREADY     = 1'b1;
		PSLVERR    = acc & ~mapped;
		BUF_FULL   = full_q;
		TX_ENABLE  = full_q & ~{1'b0, stall_q} & {5'h1F, ~(blk_q[0] | blk_q[1]), 1'b1};
		EP_STALL   = stall_q;
		EP_REINIT  = rein_q;
		DMA_SEND   = dsend_q;
		DMA_LEN    = dlen_q;
		DMA_SLOT   = dslot_q;
		RESUME_OUT = res_q != 19'h00000;
		INT_N      = ~int_q;
	end

	property p_max_xfer;
		@(posedge REF_CLK) disable iff (SRST) cnt_q <= MAX_XFER;
	endproperty
	a_max_xfer: assert property (p_max_xfer)
		else $error("buffer byte count passed limit");
	property p_out_full;
		@(posedge REF_CLK) disable iff (SRST) OUT_DONE |=> full_q[$past(USB_EP)];
	endproperty
	a_out_full: assert property (p_out_full)
		else $error("received OUT packet did not set full");
	property p_validate;
		@(posedge REF_CLK) disable iff (SRST)
		cmd_wr && PWDATA[7:0] == CMD_VALID && sel_q > 3'h1 |=> full_q[$past(sel_q)];
	endproperty
	a_validate: assert property (p_validate)
		else $error("validate did not set full");
	property p_setup;
		@(posedge REF_CLK) disable iff (SRST) SETUP_RX |=> blk_q == 2'b11 && !full_q[1];
	endproperty
	a_setup: assert property (p_setup)
		else $error("SETUP did not flush and block");
	property p_resume;
		@(posedge REF_CLK) disable iff (SRST)
		cmd_wr && PWDATA[7:0] == CMD_RESUME |=> RESUME_OUT [*8];
	endproperty
	a_resume: assert property (p_resume)
		else $error("resume signalling ended early");
	property p_select;
		@(posedge REF_CLK) disable iff (SRST)
		cmd_wr && PWDATA[7:0] <= CMD_SEL_HI |=> ptr_q == 8'h00 && sel_q == $past(PWDATA[2:0]);
	endproperty
	a_select: assert property (p_select)
		else $error("select did not reset pointer");
	property p_sof_only;
		@(posedge REF_CLK) disable iff (SRST) cfg_q[SOF_ONLY_BIT] && !SOF_RX |=> INT_N;
	endproperty
	a_sof_only: assert property (p_sof_only)
		else $error("non-SOF interrupt in SOF-only mode");
	property p_xfer_end;
		@(posedge REF_CLK) disable iff (SRST) DMA_WR && !END_OF_TRANSFER_N |=> DMA_SEND;
	endproperty
	a_xfer_end: assert property (p_xfer_end)
		else $error("end of transfer did not send buffer");
	// Any status code written with zero pulses reinit on its own endpoint
	property p_zero_sts;
		@(posedge REF_CLK) disable iff (SRST)
		dat_wr && cmd_q >= CMD_STS_LO && cmd_q <= CMD_STS_HI && cnt_q == 8'h00
			&& PWDATA[7:0] == 8'h00 |=> EP_REINIT[$past(sts_ep)];
	endproperty
	a_zero_sts: assert property (p_zero_sts)
		else $error("zero status did not reinitialize");
endmodule : ueb_core
`default_nettype wire

// >>> verilog/ueb_pkg.sv
`default_nettype none
// Shared constants of the endpoint buffer command block
package ueb_pkg;
	// Command codes
	localparam logic [7:0] CMD_SEL_LO  = 8'h00; // Select endpoint, first code
	localparam logic [7:0] CMD_SEL_HI  = 8'h05; // Select endpoint, last code
	localparam logic [7:0] CMD_STS_LO  = 8'h40; // Set endpoint status, first code
	localparam logic [7:0] CMD_STS_HI  = 8'h45; // Set endpoint status, last code
	localparam logic [7:0] CMD_BUF     = 8'hF0; // Read or write buffer
	localparam logic [7:0] CMD_ACKSET  = 8'hF1; // Acknowledge setup
	localparam logic [7:0] CMD_CLRBUF  = 8'hF2; // Clear buffer
	localparam logic [7:0] CMD_FRAME   = 8'hF5; // Read frame number
	localparam logic [7:0] CMD_RESUME  = 8'hF6; // Send resume
	localparam logic [7:0] CMD_VALID   = 8'hFA; // Validate buffer
	// Buffer layout and limits
	localparam logic [7:0] MAX_XFER    = 8'h82; // Most bytes after one buffer command
	localparam logic [7:0] HDR_BYTES   = 8'h02; // Reserved byte plus length byte
	localparam logic [2:0] EP_MAIN_IN  = 3'h5;  // Main IN endpoint, first buffer
	localparam logic [2:0] EP_ALT_BUF  = 3'h6;  // Main IN endpoint, second buffer
	localparam int         NSLOT       = 7;     // Buffer slots
	// Register byte offsets
	localparam logic [11:0] REG_CMD    = 12'h000; // Command code
	localparam logic [11:0] REG_DATA   = 12'h004; // Data phase byte
	localparam logic [11:0] REG_STAT   = 12'h008; // Flags
	localparam logic [11:0] REG_CFG    = 12'h00C; // Mode bytes
	localparam logic [11:0] REG_FRAME  = 12'h010; // Last frame number
	// Configuration fields
	localparam int SOF_ONLY_BIT = 7;  // Bit 7 of the clock division byte
	localparam int DMA_BYTE_LSB = 8;  // DMA byte sits in bits 15:8
	localparam int INT_MODE_BIT = DMA_BYTE_LSB + 5; // Bit 5 of the DMA byte
	// Timing
	localparam int RESUME_MS  = 10; // Resume signalling time in ms
	localparam int CLK_NS     = 20; // Clock period in ns
	localparam int RESUME_CYC = RESUME_MS * 1000000 / CLK_NS;
endpackage : ueb_pkg
`default_nettype wire
